/* pkg/i2cs_pkg.sv */
// i2cs_pkg: shared constants and types for the two-wire register slave link
// assumes: host side runs at 100 MHz; device link logic runs on link_clk
package i2cs_pkg;
    localparam logic [6:0] SLAVE_ADDR    = 7'h68;
    localparam int         CLK_PERIOD_NS = 10;
    localparam int         T_SCL_NS      = 2500;
    // quarter of one serial clock period, rounded down
    localparam int         QUARTER_CYC   = T_SCL_NS / (4 * CLK_PERIOD_NS);
    localparam int         BYTE_BITS     = 8;
    localparam int         CMD_W         = 10;
    localparam int         FIFO_DEPTH    = 8;
    localparam logic [7:0] PTR_RESET     = 8'h00;

    // host command opcodes, in cmd_data[9:8]
    typedef enum logic [1:0] {
        OP_START = 2'h0,
        OP_WRITE = 2'h1,
        OP_READ  = 2'h2,
        OP_STOP  = 2'h3
    } i2cs_op_t;

    // byte role inside a write transfer
    typedef enum logic [1:0] {
        PH_ADDR = 2'h0,
        PH_WORD = 2'h1,
        PH_DATA = 2'h2
    } i2cs_phase_t;
endpackage : i2cs_pkg

/* pkg/i2cs_link_if.sv */
// i2cs_link_if: the two open-drain wires plus the device's link clock
// assumes: both wires have pull-ups; bench drives link_clk
`timescale 1ns/1ps
interface i2cs_link_if;
    logic link_clk;
    logic host_scl_o;
    logic host_scl_oe;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic scl;
    logic sda;

    // wired-and with pull-up: any enabled low driver wins
    assign scl = (host_scl_oe && !host_scl_o) ? 1'b0 : 1'b1;
    assign sda = ((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o))
                 ? 1'b0 : 1'b1;

    modport dev (
        input  link_clk,
        input  scl,
        input  sda,
        output dev_sda_o,
        output dev_sda_oe
    );
    modport host (
        input  scl,
        input  sda,
        output host_scl_o,
        output host_scl_oe,
        output host_sda_o,
        output host_sda_oe
    );
endinterface : i2cs_link_if

/* core/i2cs_device.sv */
// i2cs_device: two-wire slave end with an internal byte register bank
// assumes: link_clk oversamples scl/sda many times per bit; the master
// generates every clock pulse and all start/stop conditions
`timescale 1ns/1ps
module i2cs_device #(
    parameter int PTR_W = 8
) (
    input  wire logic                        clk,
    input  wire logic                        sys_rst,
    i2cs_link_if.dev                         link,
    output logic                             upd_valid,
    output logic [PTR_W-1:0]                 upd_ptr,
    output logic [i2cs_pkg::BYTE_BITS-1:0]   upd_data
);
    import i2cs_pkg::*;

    typedef enum logic [4:0] {
        D_IDLE = 5'h01,
        D_RECV = 5'h02,
        D_ACK  = 5'h04,
        D_SEND = 5'h08,
        D_MACK = 5'h10
    } i2cs_dstate_t;

    localparam int DEPTH = 2 ** PTR_W;

    // link domain
    logic                 rst_m;
    logic                 rst_l;
    logic                 scl_m;
    logic                 scl_s;
    logic                 scl_p;
    logic                 sda_m;
    logic                 sda_s;
    logic                 sda_p;
    i2cs_dstate_t         state;
    i2cs_phase_t          phase;
    logic                 rw;
    logic                 more;
    logic [3:0]           bcnt;
    logic [7:0]           sh;
    logic [PTR_W-1:0]     ptr;
    logic                 sda_drv;
    logic [7:0]           mem [DEPTH];
    logic                 ev_tog;
    logic [PTR_W-1:0]     ev_ptr;
    logic [7:0]           ev_data;
    // clk domain
    logic                 tog_m;
    logic                 tog_s;
    logic                 tog_p;

    logic start_c;
    logic stop_c;
    logic rise;
    logic fall;
    logic byte_end;
    logic mem_we;

    // reset is a level from the other domain; two flops bring it over
    always_ff @(posedge link.link_clk) begin
        rst_m <= sys_rst;
        rst_l <= rst_m;
    end

    // scl/sda are asynchronous pins: two flops, then a third for edges
    always_ff @(posedge link.link_clk) begin
        scl_m <= link.scl;
        scl_s <= scl_m;
        scl_p <= scl_s;
        sda_m <= link.sda;
        sda_s <= sda_m;
        sda_p <= sda_s;
    end

    always_comb begin
        start_c  = scl_s && scl_p && sda_p && !sda_s;
        stop_c   = scl_s && scl_p && !sda_p && sda_s;
        rise     = scl_s && !scl_p;
        fall     = !scl_s && scl_p;
        byte_end = (state == D_RECV) && fall && (bcnt == 4'(BYTE_BITS));
        mem_we   = byte_end && (phase == PH_DATA);
    end

    // bus engine: all sda changes happen just after scl falls
    always_ff @(posedge link.link_clk) begin
        if (rst_l) begin
            state   <= D_IDLE;
            phase   <= PH_ADDR;
            rw      <= 1'b0;
            more    <= 1'b0;
            bcnt    <= 4'h0;
            sh      <= 8'h00;
            ptr     <= PTR_W'(PTR_RESET);
            sda_drv <= 1'b0;
        end else if (start_c) begin
            // also covers a repeated start in the middle of a transfer
            state   <= D_RECV;
            phase   <= PH_ADDR;
            bcnt    <= 4'h0;
            sda_drv <= 1'b0;
        end else if (stop_c) begin
            state   <= D_IDLE;
            sda_drv <= 1'b0;
        end else begin
            case (state)
                D_IDLE: begin
                    sda_drv <= 1'b0;
                end
                D_RECV: begin
                    if (rise && bcnt < 4'(BYTE_BITS)) begin
                        sh   <= {sh[6:0], sda_s};
                        bcnt <= bcnt + 4'h1;
                    end else if (byte_end) begin
                        case (phase)
                            PH_ADDR: begin
                                if (sh[7:1] == SLAVE_ADDR) begin
                                    rw      <= sh[0];
                                    sda_drv <= 1'b1;
                                    state   <= D_ACK;
                                end else begin
                                    state <= D_IDLE;
                                end
                            end
                            PH_WORD: begin
                                ptr     <= sh[PTR_W-1:0];
                                sda_drv <= 1'b1;
                                state   <= D_ACK;
                            end
                            default: begin
                                ptr     <= ptr + 1'b1;
                                sda_drv <= 1'b1;
                                state   <= D_ACK;
                            end
                        endcase
                    end
                end
                D_ACK: begin
                    if (fall) begin
                        if (rw && phase == PH_ADDR) begin
                            // pointer is whatever was last held
                            sh      <= mem[ptr];
                            sda_drv <= !mem[ptr][7];
                            bcnt    <= 4'h1;
                            state   <= D_SEND;
                        end else begin
                            sda_drv <= 1'b0;
                            bcnt    <= 4'h0;
                            state   <= D_RECV;
                            if (phase == PH_ADDR) begin
                                phase <= PH_WORD;
                            end else begin
                                phase <= PH_DATA;
                            end
                        end
                    end
                end
                D_SEND: begin
                    if (fall) begin
                        if (bcnt == 4'(BYTE_BITS)) begin
                            sda_drv <= 1'b0;
                            ptr     <= ptr + 1'b1;
                            state   <= D_MACK;
                        end else begin
                            sda_drv <= !sh[6];
                            sh      <= {sh[6:0], 1'b0};
                            bcnt    <= bcnt + 4'h1;
                        end
                    end
                end
                D_MACK: begin
                    if (rise) begin
                        more <= !sda_s;
                    end else if (fall) begin
                        if (more) begin
                            sh      <= mem[ptr];
                            sda_drv <= !mem[ptr][7];
                            bcnt    <= 4'h1;
                            state   <= D_SEND;
                        end else begin
                            state <= D_IDLE;
                        end
                    end
                end
                default: begin
                    state   <= D_IDLE;
                    sda_drv <= 1'b0;
                end
            endcase
        end
    end

    // register bank, written only by the master
    always_ff @(posedge link.link_clk) begin
        if (mem_we) begin
            mem[ptr] <= sh;
        end
    end

    // write event to the clk side: the word is held until the next data
    // byte, at least nine scl periods later, so a toggle alone suffices
    always_ff @(posedge link.link_clk) begin
        if (rst_l) begin
            ev_tog  <= 1'b0;
            ev_ptr  <= '0;
            ev_data <= 8'h00;
        end else if (mem_we) begin
            ev_tog  <= !ev_tog;
            ev_ptr  <= ptr;
            ev_data <= sh;
        end
    end

    // open drain: only ever pull low
    assign link.dev_sda_o  = 1'b0;
    assign link.dev_sda_oe = sda_drv;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tog_m     <= 1'b0;
            tog_s     <= 1'b0;
            tog_p     <= 1'b0;
            upd_valid <= 1'b0;
            upd_ptr   <= '0;
            upd_data  <= 8'h00;
        end else begin
            tog_m     <= ev_tog;
            tog_s     <= tog_m;
            tog_p     <= tog_s;
            upd_valid <= tog_s ^ tog_p;
            if (tog_s ^ tog_p) begin
                upd_ptr  <= ev_ptr;
                upd_data <= ev_data;
            end
        end
    end
endmodule : i2cs_device

/* core/i2cs_host.sv */
// i2cs_host: two-wire bus master with an 8-word command FIFO
// assumes: one slave that never stretches the clock; scl from divider
`timescale 1ns/1ps
module i2cs_fifo #(
    parameter int W     = 10,
    parameter int DEPTH = 8
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         s_valid,
    output logic              s_ready,
    input  wire logic [W-1:0] s_data,
    output logic              m_valid,
    input  wire logic         m_ready,
    output logic [W-1:0]      m_data
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0]   cnt;
    logic          push;
    logic          pop;
    logic [AW:0]   next_cnt;

    always_comb begin
        push     = s_valid && s_ready;
        pop      = m_valid && m_ready;
        next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
        m_valid  = (cnt != '0);
        m_data   = mem[rptr];
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wptr] <= s_data;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wptr    <= '0;
            rptr    <= '0;
            cnt     <= '0;
            s_ready <= 1'b1;
        end else begin
            wptr    <= (push && wptr == AW'(DEPTH-1)) ? '0 : wptr + AW'(push);
            rptr    <= (pop && rptr == AW'(DEPTH-1)) ? '0 : rptr + AW'(pop);
            cnt     <= next_cnt;
            s_ready <= (next_cnt < (AW+1)'(DEPTH));
        end
    end
endmodule : i2cs_fifo

module i2cs_host (
    input  wire logic                        clk,
    input  wire logic                        sys_rst,
    i2cs_link_if.host                        link,
    input  wire logic                        cmd_valid,
    output logic                             cmd_ready,
    input  wire logic [i2cs_pkg::CMD_W-1:0]  cmd_data,
    output logic                             rsp_valid,
    output logic [i2cs_pkg::BYTE_BITS-1:0]   rsp_data,
    output logic                             rsp_ack,
    output logic                             busy
);
    import i2cs_pkg::*;

    typedef enum logic [4:0] {
        H_IDLE  = 5'h01,
        H_HOLD  = 5'h02,
        H_START = 5'h04,
        H_BIT   = 5'h08,
        H_STOP  = 5'h10
    } i2cs_hstate_t;

    i2cs_hstate_t      state;
    logic [1:0]        q;
    logic [15:0]       qcnt;
    logic [3:0]        bcnt;
    logic [7:0]        sh;
    logic              rd;
    logic              last;
    logic              scl_drv;
    logic              sda_drv;
    logic              sda_m;
    logic              sda_s;
    logic              f_valid;
    logic              f_ready;
    logic [CMD_W-1:0]  f_data;
    logic              tick;
    i2cs_op_t          op;

    // engine stalls draining while a byte is on the wire
    i2cs_fifo #(.W(CMD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk     (clk),
        .sys_rst (sys_rst),
        .s_valid (cmd_valid),
        .s_ready (cmd_ready),
        .s_data  (cmd_data),
        .m_valid (f_valid),
        .m_ready (f_ready),
        .m_data  (f_data)
    );

    always_comb begin
        tick    = (qcnt == 16'(QUARTER_CYC - 1));
        f_ready = (state == H_IDLE) || (state == H_HOLD && q == 2'h2);
        op      = i2cs_op_t'(f_data[9:8]);
    end

    always_ff @(posedge clk) begin
        sda_m <= link.sda;
        sda_s <= sda_m;
    end

    always_ff @(posedge clk) begin
        if (sys_rst || f_ready || tick) begin
            qcnt <= 16'h0000;
        end else begin
            qcnt <= qcnt + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state     <= H_IDLE;
            q         <= 2'h0;
            bcnt      <= 4'h0;
            sh        <= 8'h00;
            rd        <= 1'b0;
            last      <= 1'b0;
            scl_drv   <= 1'b0;
            sda_drv   <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_data  <= 8'h00;
            rsp_ack   <= 1'b0;
            busy      <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            busy      <= (state != H_IDLE);
            if (f_ready && f_valid) begin
                q    <= 2'h0;
                bcnt <= 4'h0;
                sh   <= f_data[7:0];
                rd   <= (op == OP_READ);
                last <= f_data[0];
                case (op)
                    OP_START: state <= H_START;
                    OP_STOP:  state <= H_STOP;
                    default:  state <= H_BIT;
                endcase
            end else if (tick) begin
                q <= q + 2'h1;
                case (state)
                    H_START: begin
                        case (q)
                            2'h0: begin
                                scl_drv <= 1'b1;
                                sda_drv <= 1'b0;
                            end
                            2'h1: scl_drv <= 1'b0;
                            2'h2: sda_drv <= 1'b1;
                            default: begin
                                scl_drv <= 1'b1;
                                rd      <= 1'b0;
                                bcnt    <= 4'h0;
                                state   <= H_BIT;
                            end
                        endcase
                    end
                    H_BIT: begin
                        case (q)
                            2'h0: scl_drv <= 1'b1;
                            2'h1: begin
                                if (bcnt < 4'(BYTE_BITS)) begin
                                    sda_drv <= rd ? 1'b0 : !sh[7];
                                end else begin
                                    sda_drv <= rd ? !last : 1'b0;
                                end
                            end
                            2'h2: scl_drv <= 1'b0;
                            default: begin
                                bcnt <= bcnt + 4'h1;
                                if (bcnt < 4'(BYTE_BITS)) begin
                                    sh <= {sh[6:0], sda_s};
                                end else begin
                                    rsp_valid <= 1'b1;
                                    rsp_data  <= sh;
                                    rsp_ack   <= !sda_s;
                                    state     <= H_HOLD;
                                end
                            end
                        endcase
                    end
                    H_HOLD: begin
                        // park with scl low; then let sda go
                        if (q == 2'h0) begin
                            scl_drv <= 1'b1;
                        end else if (q == 2'h1) begin
                            sda_drv <= 1'b0;
                        end
                    end
                    H_STOP: begin
                        case (q)
                            2'h0: begin
                                scl_drv <= 1'b1;
                                sda_drv <= 1'b1;
                            end
                            2'h1: scl_drv <= 1'b0;
                            2'h2: sda_drv <= 1'b0;
                            default: state <= H_IDLE;
                        endcase
                    end
                    default: begin
                        state   <= H_IDLE;
                        scl_drv <= 1'b0;
                        sda_drv <= 1'b0;
                    end
                endcase
            end
        end
    end

    assign link.host_scl_o  = 1'b0;
    assign link.host_scl_oe = scl_drv;
    assign link.host_sda_o  = 1'b0;
    assign link.host_sda_oe = sda_drv;
endmodule : i2cs_host

/* dv/i2cs_link_sva.sv */
// i2cs_link_sva: protocol checks on the shared scl/sda wires
// assumes: sampled on the 100 MHz clock, which oversamples both wires
`timescale 1ns/1ps
module i2cs_link_sva (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic link_clk,
    input wire logic scl,
    input wire logic sda,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe
);
    import i2cs_pkg::*;
    logic       scl_q;
    logic       sda_q;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic       first;
    logic       rd;
    logic       quiet;
    logic       rise;
    logic       start;
    logic       stop;
    logic       slot;
    logic       hit;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    assign rise  = scl && !scl_q;
    assign start = scl && scl_q && sda_q && !sda;
    assign stop  = scl && scl_q && !sda_q && sda;
    assign slot  = rise && (cnt == 4'h8);
    assign hit   = (sh[7:1] == SLAVE_ADDR);

    always_ff @(posedge clk) begin
        scl_q <= scl;
        sda_q <= sda;
    end
    // bit position inside the current byte, ninth rise is the ack slot
    always_ff @(posedge clk) begin
        if (sys_rst || start) begin
            cnt <= 4'h0;
        end else if (rise) begin
            cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
        end
    end
    always_ff @(posedge clk) begin
        if (rise) begin
            sh <= {sh[6:0], sda};
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst || start) begin
            first <= 1'b1;
        end else if (slot) begin
            first <= 1'b0;
        end
    end
    always_ff @(posedge clk) begin
        if (slot && first) begin
            rd <= sh[0];
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst || start) begin
            quiet <= 1'b0;
        end else if (slot && first && !hit) begin
            quiet <= 1'b1;
        end
    end

    addr_ack_a: assert property (slot && first && hit |-> !sda)
        else $error("matching address not acknowledged");
    foreign_nak_a: assert property (slot && first && !hit |-> !dev_sda_oe)
        else $error("foreign address acknowledged");
    quiet_bus_a: assert property (quiet |-> !dev_sda_oe)
        else $error("device drives sda after foreign address");
    wr_ack_a: assert property (slot && !first && !rd && !quiet |-> !sda)
        else $error("written byte not acknowledged");
    rd_slot_a: assert property (slot && !first && rd |-> !dev_sda_oe)
        else $error("device holds sda in master ack slot");
    wr_quiet_a: assert property (rise && cnt != 4'h8 && (first || !rd)
        |-> !dev_sda_oe)
        else $error("device drives sda while master sends");
    sda_hold_a: assert property ($changed(dev_sda_oe) |-> !scl)
        else $error("device changes sda while scl high");
    stop_idle_a: assert property (stop |=> !dev_sda_oe [*8])
        else $error("device drives sda after stop");
    od_low_a: assert property (dev_sda_oe |-> !dev_sda_o)
        else $error("device drives sda high");
endmodule : i2cs_link_sva

/* dv/tb.sv */
// tb: host and device joined by the link, driven through host commands
// assumes: both ends from core/, checker beside the link interface
`timescale 1ns/1ps
module tb;
    import i2cs_pkg::*;
    logic             clk       = 1'b0;
    logic             sys_rst   = 1'b1;
    logic             cmd_valid = 1'b0;
    logic [CMD_W-1:0] cmd_data  = '0;
    logic             cmd_ready;
    logic             rsp_valid;
    logic             rsp_ack;
    logic             busy;
    logic             upd_valid;
    logic [7:0]       rsp_data;
    logic [7:0]       upd_ptr;
    logic [7:0]       upd_data;
    logic [8:0]       rq[$];
    logic [15:0]      uq[$];
    logic             full_seen = 1'b0;
    logic [7:0]       dat[3]    = '{8'hC4, 8'h3A, 8'h01};
    int               bad_count = 0;
    int               cmp_count = 0;

    i2cs_link_if link();
    always #5 clk = ~clk;
    // first rise comes early so the device's reset synchroniser sees
    // three link edges inside the short reset
    initial begin
        link.link_clk = 1'b0;
        #3.7;
        forever begin
            link.link_clk = ~link.link_clk;
            #32;
        end
    end

    i2cs_device u_i2cs_device (.clk(clk), .sys_rst(sys_rst), .link(link),
        .upd_valid(upd_valid), .upd_ptr(upd_ptr), .upd_data(upd_data));
    i2cs_host u_i2cs_host (.clk(clk), .sys_rst(sys_rst), .link(link),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_data(cmd_data),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ack(rsp_ack),
        .busy(busy));
    i2cs_link_sva u_i2cs_link_sva (.clk(clk), .sys_rst(sys_rst),
        .link_clk(link.link_clk), .scl(link.scl), .sda(link.sda),
        .dev_sda_o(link.dev_sda_o), .dev_sda_oe(link.dev_sda_oe));

    // sampled mid-cycle, away from the edge that launches the pulses
    always @(negedge clk) begin
        if (rsp_valid === 1'b1) begin
            rq.push_back({rsp_ack, rsp_data});
        end
        if (upd_valid === 1'b1) begin
            uq.push_back({upd_ptr, upd_data});
        end
        if (cmd_ready === 1'b0 && !sys_rst) begin
            full_seen <= 1'b1;
        end
    end

    task automatic summarize;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize

    task automatic fail_out;
        bad_count++;
        summarize();
    endtask : fail_out

    task automatic chk(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // valid stays up between calls so commands go in back to back
    task automatic send(input i2cs_op_t op, input logic [7:0] b);
        int n = 0;
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_data  = {op, b};
        // ready is settled at the falling edge; the next rising edge takes
        while (cmd_ready !== 1'b1 && n < 30000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 30000) fail_out();
        @(posedge clk);
    endtask : send

    task automatic drop;
        @(negedge clk);
        cmd_valid = 1'b0;
    endtask : drop

    task automatic rsp(input logic [7:0] d, input logic a);
        int n = 0;
        while (rq.size() == 0 && n < 30000) begin
            @(posedge clk);
            n++;
        end
        if (rq.size() == 0) fail_out();
        chk("rsp", {7'h0, rq.pop_front()}, {7'h0, a, d});
    endtask : rsp

    task automatic upd(input logic [7:0] p, input logic [7:0] d);
        int n = 0;
        while (uq.size() == 0 && n < 30000) begin
            @(posedge clk);
            n++;
        end
        if (uq.size() == 0) fail_out();
        chk("upd", uq.pop_front(), {p, d});
    endtask : upd

    task automatic idle;
        int n = 0;
        int q = 0;
        while (q < 8 && n < 30000) begin
            @(posedge clk);
            n++;
            q = (busy === 1'b0) ? q + 1 : 0;
        end
        if (q < 8) fail_out();
    endtask : idle

    initial begin
        repeat (16) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        // write across the pointer wrap, then read it back after restart
        send(OP_START, 8'hD0);
        send(OP_WRITE, 8'hFE);
        for (int i = 0; i < 3; i++) send(OP_WRITE, dat[i]);
        send(OP_STOP, 8'h00);
        send(OP_START, 8'hD0);
        send(OP_WRITE, 8'hFE);
        send(OP_START, 8'hD1);
        send(OP_READ, 8'h00);
        send(OP_READ, 8'h00);
        send(OP_READ, 8'h01);
        send(OP_STOP, 8'h00);
        drop();
        rsp(8'hD0, 1'b1);
        rsp(8'hFE, 1'b1);
        for (int i = 0; i < 3; i++) begin
            rsp(dat[i], 1'b1);
            upd(8'(8'hFE + i), dat[i]);
        end
        rsp(8'hD0, 1'b1);
        rsp(8'hFE, 1'b1);
        rsp(8'hD1, 1'b1);
        for (int i = 0; i < 3; i++) rsp(dat[i], i != 2);
        chk("fifo_full", {15'h0, full_seen}, 16'h0001);
        // pointer set with no data bytes, then a read without word address
        send(OP_START, 8'hD0);
        send(OP_WRITE, 8'h20);
        send(OP_WRITE, 8'h5B);
        send(OP_STOP, 8'h00);
        send(OP_START, 8'hD0);
        send(OP_WRITE, 8'h20);
        send(OP_STOP, 8'h00);
        send(OP_START, 8'hD1);
        send(OP_READ, 8'h01);
        send(OP_STOP, 8'h00);
        drop();
        rsp(8'hD0, 1'b1);
        rsp(8'h20, 1'b1);
        rsp(8'h5B, 1'b1);
        upd(8'h20, 8'h5B);
        rsp(8'hD0, 1'b1);
        rsp(8'h20, 1'b1);
        rsp(8'hD1, 1'b1);
        rsp(8'h5B, 1'b0);
        // foreign addresses leave the bus alone
        send(OP_START, 8'hA0);
        send(OP_WRITE, 8'h77);
        send(OP_STOP, 8'h00);
        send(OP_START, 8'hD2);
        send(OP_STOP, 8'h00);
        drop();
        rsp(8'hA0, 1'b0);
        rsp(8'h77, 1'b0);
        rsp(8'hD2, 1'b0);
        idle();
        chk("upd_count", 16'(uq.size()), 16'h0000);
        summarize();
    end
endmodule : tb
